//--- acr_config_bank.sv
// configuration register bank reached over the serial configuration port
`timescale 1ns/100ps
module acr_config_bank (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // serial configuration port
    input  wire logic        spi_sclk,
    input  wire logic        spi_csn,
    input  wire logic        spi_sdi,
    output logic             spi_sdo,
    // edge position detector
    input  wire logic        position_valid,
    input  wire logic [23:0] position_in,
    // synthesizer loop state
    input  wire logic        synth_loop_enable,
    // configuration outputs
    output logic      [15:0] full_scale_code,
    output logic             full_scale_below_min,
    output logic      [7:0]  power_mode_code,
    output logic             power_mode_low,
    output logic             power_mode_reserved,
    output logic             timestamp_input_enable,
    output logic             timestamp_pecl_enable,
    output logic             ref_clock_output,
    output logic      [7:0]  synth_feedback_divider_one
);

    // ******************************************************
    // register storage
    // ******************************************************
    logic [15:0] full_scale_range_r;
    logic [7:0]  power_mode_one_r;
    logic [7:0]  timestamp_input_control_r;
    logic [7:0]  ref_clock_output_control_r;
    logic [7:0]  synth_feedback_divider_one_r;
    logic [23:0] reference_edge_position;
    logic [7:0]  rd_data;
    logic [14:0] cur_addr;
    logic        wr_stb;
    logic [14:0] wr_addr;
    logic [7:0]  wr_data;
    logic        below_min_r;
    logic        low_r;
    logic        reserved_r;
    logic        ref_out_r;

    // ******************************************************
    // serial port and status capture
    // ******************************************************
    acr_spi_engine u_spi (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .spi_sclk (spi_sclk),
        .spi_csn  (spi_csn),
        .spi_sdi  (spi_sdi),
        .rd_data  (rd_data),
        .spi_sdo  (spi_sdo),
        .cur_addr (cur_addr),
        .wr_stb   (wr_stb),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data)
    );

    acr_edge_capture u_pos (
        .ref_clk                 (ref_clk),
        .rstn                    (rstn),
        .capture_valid           (position_valid),
        .position_in             (position_in),
        .reference_edge_position (reference_edge_position)
    );

    // ******************************************************
    // write address decode
    // ******************************************************
    // edge-position addresses are decoded only for the a_pos_no_write check, never to write
    wire wr_fs_lo = wr_stb && wr_addr == acr_pkg::ADDR_FS_LO;
    wire wr_fs_hi = wr_stb && wr_addr == acr_pkg::ADDR_FS_HI;
    wire wr_pwr   = wr_stb && wr_addr == acr_pkg::ADDR_PWR;
    wire wr_ts    = wr_stb && wr_addr == acr_pkg::ADDR_TS;
    wire wr_refo  = wr_stb && wr_addr == acr_pkg::ADDR_REFO;
    wire wr_fbdiv = wr_stb && wr_addr == acr_pkg::ADDR_FBDIV;
    wire wr_pos   = wr_stb && (wr_addr == acr_pkg::ADDR_POS0
                             || wr_addr == acr_pkg::ADDR_POS1
                             || wr_addr == acr_pkg::ADDR_POS2);

    // ******************************************************
    // read-write registers
    // ******************************************************
    // full-scale code, one setting for every channel
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            full_scale_range_r <= acr_pkg::FS_RST;
        end else begin
            if (wr_fs_lo) full_scale_range_r[7:0]  <= wr_data;
            if (wr_fs_hi) full_scale_range_r[15:8] <= wr_data;
        end
    end

    // power mode: any code is stored so it reads back as written
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            power_mode_one_r <= acr_pkg::PWR_RST;
        end else if (wr_pwr) begin
            power_mode_one_r <= wr_data;
        end
    end

    // timestamp control, reserved bits kept as written
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            timestamp_input_control_r <= acr_pkg::TS_RST;
        end else if (wr_ts) begin
            timestamp_input_control_r <= wr_data;
        end
    end

    // reference clock output control, enabled out of reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ref_clock_output_control_r <= acr_pkg::REFO_RST;
        end else if (wr_refo) begin
            ref_clock_output_control_r <= wr_data;
        end
    end

    // feedback divider byte, stored only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            synth_feedback_divider_one_r <= acr_pkg::FBDIV_RST;
        end else if (wr_fbdiv) begin
            synth_feedback_divider_one_r <= wr_data;
        end
    end

    // ******************************************************
    // decoded controls
    // ******************************************************
    // flags registered so data outputs come from flip-flops
    wire below_min_nxt = full_scale_range_r < acr_pkg::FS_MIN;
    wire low_nxt  = power_mode_one_r == acr_pkg::PWR_LOW;
    wire high_nxt = power_mode_one_r == acr_pkg::PWR_HIGH;
    wire ref_nxt  = ref_clock_output_control_r[acr_pkg::REFO_EN_BIT]
                    & synth_loop_enable;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            below_min_r <= 1'b0;
            low_r       <= 1'b0;
            reserved_r  <= 1'b0;
            ref_out_r   <= 1'b0;
        end else begin
            below_min_r <= below_min_nxt;
            low_r       <= low_nxt;
            reserved_r  <= ~low_nxt & ~high_nxt;
            ref_out_r   <= ref_nxt;
        end
    end

    // outputs straight from the storage flops
    assign full_scale_code            = full_scale_range_r;
    assign full_scale_below_min       = below_min_r;
    assign power_mode_code            = power_mode_one_r;
    assign power_mode_low             = low_r;
    assign power_mode_reserved        = reserved_r;
    assign timestamp_input_enable     =
        timestamp_input_control_r[acr_pkg::TS_EN_BIT];
    assign timestamp_pecl_enable      =
        timestamp_input_control_r[acr_pkg::TS_PECL_BIT];
    assign ref_clock_output           = ref_out_r;
    assign synth_feedback_divider_one = synth_feedback_divider_one_r;

    // ******************************************************
    // read multiplexer
    // ******************************************************
    // unmapped addresses read as zero; position byte 0 is bits 7:0
    wire sel_pos0  = cur_addr == acr_pkg::ADDR_POS0;
    wire sel_pos1  = cur_addr == acr_pkg::ADDR_POS1;
    wire sel_pos2  = cur_addr == acr_pkg::ADDR_POS2;
    wire sel_fs_lo = cur_addr == acr_pkg::ADDR_FS_LO;
    wire sel_fs_hi = cur_addr == acr_pkg::ADDR_FS_HI;
    wire sel_pwr   = cur_addr == acr_pkg::ADDR_PWR;
    wire sel_ts    = cur_addr == acr_pkg::ADDR_TS;
    wire sel_refo  = cur_addr == acr_pkg::ADDR_REFO;
    wire sel_fbdiv = cur_addr == acr_pkg::ADDR_FBDIV;

    assign rd_data =
          ({8{sel_pos0}}  & reference_edge_position[7:0])
        | ({8{sel_pos1}}  & reference_edge_position[15:8])
        | ({8{sel_pos2}}  & reference_edge_position[23:16])
        | ({8{sel_fs_lo}} & full_scale_range_r[7:0])
        | ({8{sel_fs_hi}} & full_scale_range_r[15:8])
        | ({8{sel_pwr}}   & power_mode_one_r)
        | ({8{sel_ts}}    & timestamp_input_control_r)
        | ({8{sel_refo}}  & ref_clock_output_control_r)
        | ({8{sel_fbdiv}} & synth_feedback_divider_one_r);

    // ******************************************************
    // checks
    // ******************************************************
    sequence s_fs_hi_low_write;
        wr_fs_hi && wr_data < acr_pkg::FS_MIN[15:8];
    endsequence

    sequence s_loop_off;
        !synth_loop_enable ##1 !synth_loop_enable;
    endsequence

    a_fs_write_back : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        wr_fs_lo |=> full_scale_code[7:0] == $past(wr_data))
        else $error("full-scale low byte not stored");

    a_fs_below_min : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        s_fs_hi_low_write ##1 1'b1 |=> full_scale_below_min)
        else $error("low full-scale code not flagged");

    a_pwr_low_flag : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (wr_pwr && wr_data == acr_pkg::PWR_LOW) |=> ##1 power_mode_low
                                                    && !power_mode_reserved)
        else $error("low power code not decoded");

    a_pwr_reserved : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (wr_pwr && wr_data != acr_pkg::PWR_LOW && wr_data != acr_pkg::PWR_HIGH)
        |=> ##1 power_mode_reserved && power_mode_code == $past(wr_data, 2))
        else $error("reserved power code not flagged");

    a_ts_enable : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        wr_ts |=> timestamp_input_enable == $past(wr_data[0]))
        else $error("timestamp enable not following write");

    a_refclk_gate : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        s_loop_off |-> !ref_clock_output)
        else $error("reference clock driven with loop off");

    a_refclk_reset : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(rstn) |-> ref_clock_output_control_r == acr_pkg::REFO_RST)
        else $error("reference clock enable not set after reset");

    a_pos_no_write : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (wr_pos && !position_valid) |=> $stable(reference_edge_position))
        else $error("edge position changed by host write");

    // the gate check alone would pass with the output stuck low
    a_refclk_on : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (ref_clock_output_control_r[acr_pkg::REFO_EN_BIT]
         && synth_loop_enable) |=> ref_clock_output)
        else $error("reference clock not driven when enabled");

    a_pwr_high_flag : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (wr_pwr && wr_data == acr_pkg::PWR_HIGH) |=> ##1 !power_mode_low
                                                     && !power_mode_reserved)
        else $error("high performance code not decoded");

endmodule : acr_config_bank

//--- acr_pkg.sv
// constants, register map and types of the configuration register bank
// Functional notes
// - report 24-bit reference edge position against the sampling clock
// - one 16-bit full-scale code, reset 0xA000, shared by all channels
// - code 0x2000 is 500 mVPP minimum, 0xA000 800, 0xFFFF 1000 mVPP
// - power-mode code 0x46 low power, 0x4B high performance at reset
// - timestamp control bit 0 enables the timestamp receiver, off at reset
// - reference clock output driven only when enable and synth loop set
// - reference clock output enable resets to 1, needing no write
// - edge-position status is read-only, host writes are ignored
package acr_pkg;

    // ******************************************************
    // serial frame layout
    // ******************************************************
    localparam int          ADDR_W        = 15;
    localparam int          DATA_W        = 8;
    localparam int          POS_W         = 24;
    localparam int          FS_W          = 16;
    localparam logic [4:0]  CNT_HDR_LAST  = 5'h0F;
    localparam logic [4:0]  CNT_BYTE_LAST = 5'h07;
    localparam logic [4:0]  CNT_ZERO      = 5'h00;
    localparam logic [4:0]  CNT_ONE       = 5'h01;
    localparam int          RW_BIT        = 15;

    // ******************************************************
    // register byte addresses
    // ******************************************************
    localparam logic [14:0] ADDR_POS0  = 15'h002C;
    localparam logic [14:0] ADDR_POS1  = 15'h002D;
    localparam logic [14:0] ADDR_POS2  = 15'h002E;
    localparam logic [14:0] ADDR_FS_LO = 15'h0030;
    localparam logic [14:0] ADDR_FS_HI = 15'h0031;
    localparam logic [14:0] ADDR_PWR   = 15'h0037;
    localparam logic [14:0] ADDR_TS    = 15'h003B;
    localparam logic [14:0] ADDR_REFO  = 15'h003C;
    localparam logic [14:0] ADDR_FBDIV = 15'h003D;
    localparam logic [14:0] ADDR_ONE   = 15'h0001;

    // ******************************************************
    // reset values and codes
    // ******************************************************
    localparam logic [23:0] POS_RST    = 24'h00_0000;
    localparam logic [15:0] FS_RST     = 16'hA000;
    localparam logic [15:0] FS_MIN     = 16'h2000;
    localparam logic [7:0]  PWR_RST    = 8'h4B;
    localparam logic [7:0]  PWR_LOW    = 8'h46;
    localparam logic [7:0]  PWR_HIGH   = 8'h4B;
    localparam logic [7:0]  TS_RST     = 8'h00;
    localparam logic [7:0]  REFO_RST   = 8'h01;
    localparam logic [7:0]  FBDIV_RST  = 8'h00;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam int          TS_EN_BIT  = 0;
    localparam int          TS_PECL_BIT = 1;
    localparam int          REFO_EN_BIT = 0;

    // serial port sequencer states
    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_HDR,
        SPI_DATA
    } acr_spi_e;

endpackage : acr_pkg

//--- acr_edge_capture.sv
// edge-position status register, loaded only by the position detector
`timescale 1ns/100ps
module acr_edge_capture (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        capture_valid,
    input  wire logic [23:0] position_in,
    output logic      [23:0] reference_edge_position
);

    // ******************************************************
    // capture register
    // ******************************************************
    // no write port at all, so host writes cannot disturb it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reference_edge_position <= acr_pkg::POS_RST;
        end else if (capture_valid) begin
            reference_edge_position <= position_in;
        end
    end

    a_pos_capture : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        capture_valid |=> reference_edge_position == $past(position_in))
        else $error("edge position not captured");

endmodule : acr_edge_capture

//--- acr_spi_engine.sv
// serial configuration port: header decode, byte streaming, read shift
`timescale 1ns/100ps
module acr_spi_engine (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        spi_sclk,
    input  wire logic        spi_csn,
    input  wire logic        spi_sdi,
    input  wire logic [7:0]  rd_data,
    output logic             spi_sdo,
    output logic      [14:0] cur_addr,
    output logic             wr_stb,
    output logic      [14:0] wr_addr,
    output logic      [7:0]  wr_data
);

    acr_pkg::acr_spi_e state_r;
    acr_pkg::acr_spi_e state_nxt;
    logic        sclk_d_r;
    logic [4:0]  cnt_r;
    logic [15:0] hdr_r;
    logic [7:0]  byte_r;
    logic [7:0]  out_r;
    logic        rd_r;

    // ******************************************************
    // edge detection and shift values
    // ******************************************************
    // inputs are synchronous to ref_clk, so one delay stage suffices
    wire         rise     = spi_sclk & ~sclk_d_r & ~spi_csn;
    wire         fall     = ~spi_sclk & sclk_d_r & ~spi_csn;
    wire [15:0]  hdr_nxt  = {hdr_r[14:0], spi_sdi};
    wire [7:0]   byte_nxt = {byte_r[6:0], spi_sdi};
    wire         hdr_done = rise && state_r == acr_pkg::SPI_HDR
                            && cnt_r == acr_pkg::CNT_HDR_LAST;
    wire         byte_done = rise && state_r == acr_pkg::SPI_DATA
                            && cnt_r == acr_pkg::CNT_BYTE_LAST;
    wire         first_fall = fall && state_r == acr_pkg::SPI_DATA
                            && cnt_r == acr_pkg::CNT_ZERO;

    // next state of the sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            acr_pkg::SPI_IDLE: if (!spi_csn) state_nxt = acr_pkg::SPI_HDR;
            acr_pkg::SPI_HDR:  if (hdr_done) state_nxt = acr_pkg::SPI_DATA;
            acr_pkg::SPI_DATA: state_nxt = acr_pkg::SPI_DATA;
            default:           state_nxt = acr_pkg::SPI_IDLE;
        endcase
        if (spi_csn) state_nxt = acr_pkg::SPI_IDLE;
    end

    // ******************************************************
    // sequencer and bit counter
    // ******************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r  <= acr_pkg::SPI_IDLE;
            sclk_d_r <= 1'b0;
            cnt_r    <= acr_pkg::CNT_ZERO;
        end else begin
            state_r  <= state_nxt;
            sclk_d_r <= spi_sclk;
            if (spi_csn || hdr_done || byte_done) cnt_r <= acr_pkg::CNT_ZERO;
            else if (rise) cnt_r <= cnt_r + acr_pkg::CNT_ONE;
        end
    end

    // header, address and byte shift; address ascends per byte
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hdr_r    <= 16'h0000;
            byte_r   <= acr_pkg::BYTE_ZERO;
            rd_r     <= 1'b0;
            cur_addr <= 15'h0000;
        end else begin
            if (rise) hdr_r <= hdr_nxt;
            if (rise) byte_r <= byte_nxt;
            if (hdr_done) begin
                rd_r     <= hdr_nxt[acr_pkg::RW_BIT];
                cur_addr <= hdr_nxt[14:0];
            end else if (byte_done) begin
                cur_addr <= cur_addr + acr_pkg::ADDR_ONE;
            end
        end
    end

    // write strobe with its address and data, one cycle wide
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_stb  <= 1'b0;
            wr_addr <= 15'h0000;
            wr_data <= acr_pkg::BYTE_ZERO;
        end else begin
            wr_stb  <= byte_done && !rd_r;
            wr_addr <= cur_addr;
            wr_data <= byte_nxt;
        end
    end

    // ******************************************************
    // read data shift, changes on falling serial clock
    // ******************************************************
    // rd_data is sampled late so a write earlier in the stream shows
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            out_r   <= acr_pkg::BYTE_ZERO;
            spi_sdo <= 1'b0;
        end else if (spi_csn) begin
            spi_sdo <= 1'b0;
        end else if (first_fall && rd_r) begin
            spi_sdo <= rd_data[7];
            out_r   <= {rd_data[6:0], 1'b0};
        end else if (fall && rd_r && state_r == acr_pkg::SPI_DATA) begin
            spi_sdo <= out_r[7];
            out_r   <= {out_r[6:0], 1'b0};
        end
    end

    sequence s_wr_byte;
        byte_done && !rd_r;
    endsequence

    a_wr_strobe : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        s_wr_byte |=> wr_stb && wr_addr == $past(cur_addr)
                      ##0 wr_data == $past(byte_nxt))
        else $error("write byte not strobed");

    a_rd_first_bit : assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (first_fall && rd_r) |=> spi_sdo == $past(rd_data[7]))
        else $error("read data msb not shifted out");

endmodule : acr_spi_engine

//--- acr_host_model.sv
// host controller model driving the serial configuration port
`timescale 1ns/100ps
module acr_host_model (
    input  wire logic ref_clk,
    output logic      spi_sclk,
    output logic      spi_csn,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    // port idles deselected with the serial clock parked low
    initial begin
        spi_sclk = 1'b0;
        spi_csn  = 1'b1;
        spi_sdi  = 1'b0;
    end

    // one bit: low three cycles so sdo has settled before the rise
    task automatic bitx(input logic b, output logic s);
        @(negedge ref_clk);
        spi_sdi = b;
        repeat (2) @(negedge ref_clk);
        spi_sclk = 1'b1;
        s        = spi_sdo;
        repeat (2) @(negedge ref_clk);
        spi_sclk = 1'b0;
    endtask : bitx

    // one frame: header then nb bytes, read bytes gathered in q
    task automatic xfer(input logic rd, input logic [14:0] a,
                        input logic [15:0] d, input int nb,
                        output logic [15:0] q);
        logic [31:0] w;
        logic        s;
        w = {rd, a, d};
        q = 16'h0000;
        @(negedge ref_clk);
        spi_csn = 1'b0;
        for (int i = 31; i >= 16 - 8 * nb; i--) begin
            bitx(w[i], s);
            if (i < 16) q = {q[14:0], s};
        end
        @(negedge ref_clk);
        spi_csn = 1'b1;
        spi_sdi = ~spi_sdi; // released line must not show stale data
        @(negedge ref_clk);
    endtask : xfer
endmodule : acr_host_model

//--- adc_config_register_bank_tb.sv
// self-checking bench of the configuration register bank
`timescale 1ns/100ps
module adc_config_register_bank_tb;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        position_valid = 1'b0;
    logic        synth_loop_enable = 1'b1;
    logic [23:0] position_in = 24'h00_0000;
    logic        spi_sclk, spi_csn, spi_sdi, spi_sdo;
    logic [15:0] full_scale_code, q, w16;
    logic [7:0]  power_mode_code, synth_feedback_divider_one, v;
    logic        full_scale_below_min, power_mode_low, power_mode_reserved;
    logic        timestamp_input_enable, timestamp_pecl_enable;
    logic        ref_clock_output;
    logic [23:0] pos;
    int          mismatches = 0;
    int          checks_done = 0;
    logic [14:0] ra [7] = '{15'h0030, 15'h0031, 15'h0037, 15'h003B,
                            15'h003C, 15'h003D, 15'h0001};
    logic [7:0]  rv [7] = '{8'h00, 8'hA0, 8'h4B, 8'h00, 8'h01, 8'h00, 8'h00};
    logic [15:0] fsc [4] = '{16'h1FFF, 16'h2000, 16'hFFFF, 16'h0000};
    logic [7:0]  pm [2] = '{8'h46, 8'h4B};

    always #25 ref_clk = ~ref_clk;

    acr_config_bank acr_config_bank_inst (.ref_clk, .rstn, .spi_sclk,
        .spi_csn, .spi_sdi, .spi_sdo, .position_valid, .position_in,
        .synth_loop_enable, .full_scale_code, .full_scale_below_min,
        .power_mode_code, .power_mode_low, .power_mode_reserved,
        .timestamp_input_enable, .timestamp_pecl_enable, .ref_clock_output,
        .synth_feedback_divider_one);
    acr_host_model acr_host_model_inst (.ref_clk, .spi_sclk, .spi_csn,
        .spi_sdi, .spi_sdo);

    // ******************************************************
    // checking helpers
    // ******************************************************
    task automatic chk(input string nm, input logic [23:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        acr_host_model_inst.xfer(1'b0, a, {d, 8'h00}, 1, q);
    endtask : wr
    task automatic rd(input logic [14:0] a, output logic [7:0] d);
        acr_host_model_inst.xfer(1'b1, a, 16'h0000, 1, q);
        d = q[7:0];
    endtask : rd
    function automatic logic exp_low(input logic [15:0] c);
        return c < 16'h2000;
    endfunction : exp_low
    function automatic logic exp_rsv(input logic [7:0] c);
        return c != 8'h46 && c != 8'h4B;
    endfunction : exp_rsv

    // main sequence; every stimulus lands on the falling edge
    initial begin
        void'($urandom(75232));
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], v);
            chk("reset rd", v, rv[i]);
        end
        chk("refo reset", ref_clock_output, 1'b1);
        // the host reads the position before choosing a delay
        pos = 24'($urandom);
        position_in = pos;
        position_valid = 1'b1;
        @(negedge ref_clk);
        position_valid = 1'b0;
        position_in = ~pos; // detector moves on, status must hold
        wr(15'h002C, ~pos[7:0]);
        for (int i = 0; i < 3; i++) begin
            rd(15'(15'h002C + i), v);
            chk("pos", v, pos[8*i +: 8]);
        end
        // boundary codes first, then random ones, streamed as two bytes
        for (int i = 0; i < 8; i++) begin
            w16 = (i < 4) ? fsc[i] : 16'($urandom);
            acr_host_model_inst.xfer(1'b0, 15'h0030, {w16[7:0], w16[15:8]},
                                     2, q);
            chk("fs", full_scale_code, w16);
            chk("fs min", full_scale_below_min, exp_low(w16));
            acr_host_model_inst.xfer(1'b1, 15'h0030, 16'h0000, 2, q);
            chk("fs rd", {q[7:0], q[15:8]}, w16);
        end
        // calibration and link stay idle; companion mode registers
        // sit outside this bank
        // a reserved code first, so the flag is seen set and cleared
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'($urandom) : pm[i - 1];
            if (i == 0 && !exp_rsv(v)) v = v ^ 8'h01;
            wr(15'h0037, v);
            chk("pwr", power_mode_code, v);
            chk("pwr low", power_mode_low, v == 8'h46);
            chk("pwr rsv", power_mode_reserved, exp_rsv(v));
            rd(15'h0037, w16[7:0]);
            chk("pwr rd", w16[7:0], v);
        end
        // reserved bits written with their reset value only
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom) & 8'h03;
            wr(15'h003B, v);
            chk("ts en", timestamp_input_enable, v[0]);
            chk("ts pecl", timestamp_pecl_enable, v[1]);
            rd(15'h003B, w16[15:8]);
            chk("ts rd", w16[15:8], v);
            synth_loop_enable = i[1];
            wr(15'h003C, {7'h00, i[0]});
            chk("refo", ref_clock_output, i[0] & i[1]);
            v = 8'($urandom) & 8'h0F;
            wr(15'h003D, v);
            chk("div", synth_feedback_divider_one, v);
            rd(15'h003D, w16[7:0]);
            chk("div rd", w16[7:0], v);
        end
        // reset in mid-run restores the enable that was just cleared
        wr(15'h003C, 8'h00);
        chk("refo off", ref_clock_output, 1'b0);
        rstn = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("fs rst", full_scale_code, 16'hA000);
        rstn = 1'b1;
        @(negedge ref_clk);
        chk("refo out2", ref_clock_output, 1'b1);
        rd(15'h003C, v);
        chk("refo rd2", v, 8'h01);
        wrap_up();
    end

    // watchdog well beyond the 75 frames above
    initial begin
        repeat (40000) @(posedge ref_clk);
        mismatches++;
        wrap_up();
    end
endmodule : adc_config_register_bank_tb
